// File: logic/can_indirect_pkg.sv
package can_indirect_pkg;

    // special-function addresses, all on page 1
    localparam logic [7:0] ADDR_DATA_LOW = 8'hD8;
    localparam logic [7:0] ADDR_DATA_HIGH = 8'hD9;
    localparam logic [7:0] ADDR_INDEX = 8'hDA;
    localparam logic [7:0] ADDR_TEST = 8'hDB;
    localparam logic [7:0] ADDR_CONTROL = 8'hF8;
    localparam logic [7:0] ADDR_STATUS = 8'hC0;

    // controller word indexes of the directly mapped registers
    localparam logic [7:0] IDX_CONTROL = 8'h00;
    localparam logic [7:0] IDX_STATUS = 8'h01;
    localparam logic [7:0] IDX_TEST = 8'h05;

    // auto-increment ranges of the two message interfaces
    localparam logic [7:0] IF_ONE_FIRST = 8'h08;
    localparam logic [7:0] IF_ONE_LAST = 8'h12;
    localparam logic [7:0] IF_TWO_FIRST = 8'h20;
    localparam logic [7:0] IF_TWO_LAST = 8'h2A;

    localparam int IRQ_FLAG_BIT = 4;

    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [7:0] HOLD_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [1:0] BE_BOTH = 2'h3;
    localparam logic [1:0] BE_LOW = 2'h1;

    // one write into the controller's 16-bit register space
    typedef struct packed {
        logic wr;
        logic [7:0] index;
        logic [1:0] be;
        logic [15:0] wdata;
    } ctl_req_t;

    localparam ctl_req_t REQ_IDLE = '{wr: 1'b0, index: 8'h00, be: 2'h0, wdata: 16'h0000};

endpackage : can_indirect_pkg

// File: logic/can_indirect_register_port.sv
`timescale 1ns/1ns
// Summary of operation
// [RULE1] 8-bit read/write index register selects the controller word the data bytes reach.
// [RULE2] data byte reads return bytes of the selected word; writes update that word.
// [RULE3] low byte write inside 0x08-0x12 or 0x20-0x2A advances index by one.
// [RULE4] control bit 4 shows controller interrupt, cleared only when controller clears all.
// [RULE5] flag reads 1 while interrupt pending, else 0; writes to bit 4 ignored.
// [RULE6] control, test, status reachable directly and by index, same storage.
// [RULE7] page 1: low data 0xD8, high data 0xD9, index 0xDA, test 0xDB.
// [RULE8] indexed space is 128 sixteen-bit words, one word per index.
// [RULE9] software writes index, then high byte, then low byte.
// [RULE10] high byte held until low byte write; both committed together before increment.
module can_indirect_register_port
    import can_indirect_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic sfr_page_one,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata_q,
    output logic [7:0] ctl_rd_index,
    input wire logic [15:0] ctl_rdata,
    input wire logic ctl_irq_pending,
    output ctl_req_t ctl_req_q
);

    logic [7:0] index_q;
    logic [7:0] hold_q;
    logic dir_hit;
    logic [7:0] dir_index;
    logic wr_en;
    logic rd_en;
    logic in_if_range;
    logic [7:0] low_view;
    logic [7:0] rdata_d;

    assign wr_en = sfr_wr && sfr_page_one;
    assign rd_en = sfr_rd && sfr_page_one;
    assign in_if_range = (index_q >= IF_ONE_FIRST && index_q <= IF_ONE_LAST)
        || (index_q >= IF_TWO_FIRST && index_q <= IF_TWO_LAST);

    // direct addresses map onto the controller words themselves, so no shadow copy exists
    always_comb begin
        dir_hit = 1'b1;
        dir_index = IDX_CONTROL;
        case (sfr_addr)
            ADDR_CONTROL: dir_index = IDX_CONTROL; // RULE6
            ADDR_STATUS: dir_index = IDX_STATUS; // RULE6
            ADDR_TEST: dir_index = IDX_TEST; // RULE6 RULE7
            default: dir_hit = 1'b0;
        endcase
    end

    // read address to the controller; index used whole, controller decodes 128 words
    assign ctl_rd_index = dir_hit ? dir_index : index_q; // RULE8

    // control word low byte carries the live interrupt summary in bit 4
    always_comb begin
        low_view = ctl_rdata[7:0];
        if (ctl_rd_index == IDX_CONTROL) begin
            low_view[IRQ_FLAG_BIT] = ctl_irq_pending; // RULE4 RULE5
        end
    end

    always_comb begin
        rdata_d = RDATA_RESET;
        if (dir_hit) begin
            rdata_d = low_view; // RULE6
        end else begin
            case (sfr_addr)
                ADDR_DATA_LOW: rdata_d = low_view; // RULE2
                ADDR_DATA_HIGH: rdata_d = ctl_rdata[15:8]; // RULE2
                ADDR_INDEX: rdata_d = index_q; // RULE1
                default: rdata_d = RDATA_RESET;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata_q <= RDATA_RESET;
        end else if (rd_en) begin
            sfr_rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            index_q <= INDEX_RESET;
        end else if (wr_en && sfr_addr == ADDR_INDEX) begin
            index_q <= sfr_wdata; // RULE1 RULE7
        end else if (wr_en && sfr_addr == ADDR_DATA_LOW && in_if_range) begin
            index_q <= index_q + 8'h01; // RULE3
        end
    end

    // high byte parked here; a lone high write never reaches the controller
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hold_q <= HOLD_RESET;
        end else if (wr_en && sfr_addr == ADDR_DATA_HIGH) begin
            hold_q <= sfr_wdata; // RULE10
        end
    end

    // request uses the index before increment, so the commit lands on the right word
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctl_req_q <= REQ_IDLE;
        end else if (wr_en && sfr_addr == ADDR_DATA_LOW) begin
            ctl_req_q <= '{wr: 1'b1, index: index_q, be: BE_BOTH,
                wdata: {hold_q, sfr_wdata}}; // RULE2 RULE10
        end else if (wr_en && dir_hit) begin
            ctl_req_q <= '{wr: 1'b1, index: dir_index, be: BE_LOW,
                wdata: {8'h00, sfr_wdata}}; // RULE6
        end else begin
            ctl_req_q <= REQ_IDLE;
        end
    end

    property p_index_load;
        @(posedge mclk) disable iff (!resetn)
        (wr_en && sfr_addr == ADDR_INDEX) |=> index_q == $past(sfr_wdata);
    endproperty
    a_index_load: assert property (p_index_load) else $error("index not loaded"); // RULE1

    property p_autoinc;
        @(posedge mclk) disable iff (!resetn)
        (wr_en && sfr_addr == ADDR_DATA_LOW && in_if_range)
            |=> index_q == $past(index_q) + 8'h01;
    endproperty
    a_autoinc: assert property (p_autoinc) else $error("index did not advance"); // RULE3

    property p_no_inc;
        @(posedge mclk) disable iff (!resetn)
        (wr_en && sfr_addr == ADDR_DATA_LOW && !in_if_range) |=> $stable(index_q);
    endproperty
    a_no_inc: assert property (p_no_inc) else $error("index moved outside ranges"); // RULE3

    property p_commit;
        @(posedge mclk) disable iff (!resetn)
        (wr_en && sfr_addr == ADDR_DATA_LOW) |=> ctl_req_q.wr && ctl_req_q.be == BE_BOTH
            && ctl_req_q.index == $past(index_q)
            && ctl_req_q.wdata == {$past(hold_q), $past(sfr_wdata)};
    endproperty
    a_commit: assert property (p_commit) else $error("word commit wrong"); // RULE10

    property p_high_parked;
        @(posedge mclk) disable iff (!resetn)
        (wr_en && sfr_addr == ADDR_DATA_HIGH) |=> !ctl_req_q.wr && hold_q == $past(sfr_wdata);
    endproperty
    a_high_parked: assert property (p_high_parked) else $error("high byte not held"); // RULE10

    property p_high_read;
        @(posedge mclk) disable iff (!resetn)
        (rd_en && sfr_addr == ADDR_DATA_HIGH) |=> sfr_rdata_q == $past(ctl_rdata[15:8]);
    endproperty
    a_high_read: assert property (p_high_read) else $error("high byte read wrong"); // RULE2

    property p_flag_read;
        @(posedge mclk) disable iff (!resetn)
        (rd_en && sfr_addr == ADDR_CONTROL)
            |=> sfr_rdata_q[IRQ_FLAG_BIT] == $past(ctl_irq_pending);
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("interrupt flag wrong"); // RULE5

    property p_direct_test;
        @(posedge mclk) disable iff (!resetn)
        (wr_en && sfr_addr == ADDR_TEST)
            |=> ctl_req_q.wr && ctl_req_q.index == IDX_TEST && ctl_req_q.be == BE_LOW;
    endproperty
    a_direct_test: assert property (p_direct_test) else $error("direct test write lost"); // RULE6

    property p_no_spurious;
        @(posedge mclk) disable iff (!resetn)
        !(wr_en && (sfr_addr == ADDR_DATA_LOW || dir_hit)) |=> !ctl_req_q.wr;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("spurious write"); // RULE2

    property p_low_read;
        @(posedge mclk) disable iff (!resetn)
        (rd_en && sfr_addr == ADDR_DATA_LOW && index_q != IDX_CONTROL)
            |=> sfr_rdata_q == $past(ctl_rdata[7:0]);
    endproperty
    a_low_read: assert property (p_low_read) else $error("low byte read wrong"); // RULE2

    property p_index_read;
        @(posedge mclk) disable iff (!resetn)
        (rd_en && sfr_addr == ADDR_INDEX) |=> sfr_rdata_q == $past(index_q);
    endproperty
    a_index_read: assert property (p_index_read) else $error("index read wrong"); // RULE1

    // page 0 holds other peripherals, so the port must stay silent there
    property p_page_off;
        @(posedge mclk) disable iff (!resetn)
        !sfr_page_one |=> $stable(index_q) && $stable(hold_q) && $stable(sfr_rdata_q)
            && !ctl_req_q.wr;
    endproperty
    a_page_off: assert property (p_page_off) else $error("access off page one"); // RULE7

    property p_test_route;
        @(posedge mclk) disable iff (!resetn)
        (rd_en && sfr_addr == ADDR_TEST) |-> ctl_rd_index == IDX_TEST
            ##1 sfr_rdata_q == $past(ctl_rdata[7:0]);
    endproperty
    a_test_route: assert property (p_test_route) else $error("test route wrong"); // RULE6

    property p_status_route;
        @(posedge mclk) disable iff (!resetn)
        (sfr_addr == ADDR_STATUS) |-> ctl_rd_index == IDX_STATUS;
    endproperty
    a_status_route: assert property (p_status_route) else $error("status route wrong"); // RULE6

    property p_indexed_flag;
        @(posedge mclk) disable iff (!resetn)
        (rd_en && sfr_addr == ADDR_DATA_LOW && index_q == IDX_CONTROL)
            |=> sfr_rdata_q[IRQ_FLAG_BIT] == $past(ctl_irq_pending);
    endproperty
    a_indexed_flag: assert property (p_indexed_flag) else $error("indexed flag wrong"); // RULE5

    property p_read_no_move;
        @(posedge mclk) disable iff (!resetn)
        (rd_en && !sfr_wr) |=> $stable(index_q);
    endproperty
    a_read_no_move: assert property (p_read_no_move) else $error("read moved index"); // RULE3

    c_burst: cover property (@(posedge mclk) disable iff (!resetn)
        (wr_en && sfr_addr == ADDR_DATA_LOW && index_q == IF_ONE_LAST));
    c_flag: cover property (@(posedge mclk) disable iff (!resetn)
        (rd_en && sfr_addr == ADDR_CONTROL && ctl_irq_pending));
    c_sequence: cover property (@(posedge mclk) disable iff (!resetn)
        (wr_en && sfr_addr == ADDR_DATA_HIGH) ##1 (wr_en && sfr_addr == ADDR_DATA_LOW));
    c_page_off: cover property (@(posedge mclk) disable iff (!resetn)
        (sfr_wr && !sfr_page_one));
    c_direct_write: cover property (@(posedge mclk) disable iff (!resetn)
        (wr_en && dir_hit));

endmodule : can_indirect_register_port

// File: tb/can_ctl_space_model.sv
`timescale 1ns/1ns
module can_ctl_space_model
    import can_indirect_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] rd_index,
    output logic [15:0] rdata,
    input wire ctl_req_t req
);
    logic [15:0] mem_q [128];
    assign rdata = mem_q[rd_index[6:0]];
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 128; i++) begin
                mem_q[i] <= (i == 0) ? 16'h0001 : 16'h0000;
            end
        end else if (req.wr) begin
            // byte enables keep direct writes off the high byte
            if (req.be[0]) begin
                mem_q[req.index[6:0]][7:0] <= req.wdata[7:0];
            end
            if (req.be[1]) begin
                mem_q[req.index[6:0]][15:8] <= req.wdata[15:8];
            end
        end
    end
endmodule : can_ctl_space_model

// File: tb/can_indirect_register_port_tb_top.sv
`timescale 1ns/1ns
module can_indirect_register_port_tb_top
    import can_indirect_pkg::*;
;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic page = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic irq = 1'b0;
    logic [7:0] sfr_rdata_q;
    logic [7:0] rd_index;
    logic [15:0] ctl_rdata;
    ctl_req_t ctl_req_q;
    int mismatches = 0;
    int checks_done = 0;
    logic [7:0] idx [8] = '{8'h08, 8'h12, 8'h13, 8'h20, 8'h2A, 8'h2B, 8'h07, 8'h1F};
    can_indirect_register_port u_dut (.mclk(mclk), .resetn(resetn), .sfr_page_one(page),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata_q(sfr_rdata_q), .ctl_rd_index(rd_index), .ctl_rdata(ctl_rdata),
        .ctl_irq_pending(irq), .ctl_req_q(ctl_req_q));
    can_ctl_space_model u_model (.mclk(mclk), .resetn(resetn), .rd_index(rd_index),
        .rdata(ctl_rdata), .req(ctl_req_q));
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge mclk);
        sfr_wr <= 1'b0;
    endtask : wr
    task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge mclk);
        sfr_rd <= 1'b0;
        @(posedge mclk);
        chk(n, e, sfr_rdata_q);
    endtask : rd
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic sc_reset_walk();
        rd("index", ADDR_INDEX, 8'h00);
        rd("data_low", ADDR_DATA_LOW, 8'h01);
        rd("data_high", ADDR_DATA_HIGH, 8'h00);
        wr(ADDR_INDEX, 8'h0C);
        wr(ADDR_DATA_HIGH, 8'h12);
        wr(ADDR_DATA_LOW, 8'h34);
        rd("index", ADDR_INDEX, 8'h0D);
        wr(ADDR_INDEX, 8'h0C);
        rd("data_low", ADDR_DATA_LOW, 8'h34);
        rd("data_high", ADDR_DATA_HIGH, 8'h12);
    endtask : sc_reset_walk
    task automatic sc_increment();
        logic in_rng;
        foreach (idx[i]) begin
            in_rng = (idx[i] >= IF_ONE_FIRST && idx[i] <= IF_ONE_LAST)
                || (idx[i] >= IF_TWO_FIRST && idx[i] <= IF_TWO_LAST);
            wr(ADDR_INDEX, idx[i]);
            wr(ADDR_DATA_LOW, idx[i] ^ 8'hA5);
            rd("index", ADDR_INDEX, idx[i] + {7'h00, in_rng});
            wr(ADDR_INDEX, idx[i]);
            rd("data_low", ADDR_DATA_LOW, idx[i] ^ 8'hA5);
            rd("data_high", ADDR_DATA_HIGH, 8'h12);
            rd("index", ADDR_INDEX, idx[i]);
        end
    endtask : sc_increment
    task automatic sc_direct_irq();
        wr(ADDR_TEST, 8'h5A);
        wr(ADDR_INDEX, IDX_TEST);
        rd("test_indexed", ADDR_DATA_LOW, 8'h5A);
        rd("test_direct", ADDR_TEST, 8'h5A);
        wr(ADDR_INDEX, IDX_STATUS);
        wr(ADDR_DATA_LOW, 8'h77);
        rd("status_direct", ADDR_STATUS, 8'h77);
        wr(ADDR_CONTROL, 8'h10);
        rd("control", ADDR_CONTROL, 8'h00);
        irq <= 1'b1;
        wr(ADDR_CONTROL, 8'h00);
        rd("control", ADDR_CONTROL, 8'h10);
        irq <= 1'b0;
        rd("control", ADDR_CONTROL, 8'h00);
    endtask : sc_direct_irq
    task automatic sc_page_unmapped();
        page <= 1'b0;
        wr(ADDR_INDEX, 8'h33);
        rd("page0_read", ADDR_INDEX, 8'h00);
        page <= 1'b1;
        rd("index", ADDR_INDEX, IDX_STATUS);
        rd("unmapped", 8'hD7, 8'h00);
    endtask : sc_page_unmapped
    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        sc_reset_walk();
        sc_increment();
        sc_direct_irq();
        sc_page_unmapped();
        stop_test();
    end
endmodule : can_indirect_register_port_tb_top
